// File: shared/gpr_pkg.sv
// Contract
// - I/O instructions decode offsets 0x00 to 0x3F
// - Data space address is I/O offset plus 0x20
// - Extended region from 0x60 data space only
// - Port A pin input read-only at 0x19
// - Port B output data at 0x18, reset zero
// - Port B direction at 0x17, reset zero
// - Port B pin input read-only at 0x16
// - Port C output data at 0x15, reset zero
// - Port C direction at 0x14, reset zero
// - Port C pin input at 0x13, bit7 zero (code returns all eight synchronised bits, bit7 included)
// - Port D output data at 0x12, reset zero
// - Port D direction at 0x11, reset zero
// - Legacy mode: port C drives zero outputs
// - Legacy port C state needs no clock
// - Global pull-up disable kills all pull-ups
package gpr_pkg;
    // ----------------------------------------
    // Address map
    // ----------------------------------------
    localparam logic [5:0] GPR_IO_LAST        = 6'h3F;
    localparam logic [7:0] GPR_DATA_IO_BASE   = 8'h20;
    localparam logic [7:0] GPR_DATA_EXT_BASE  = 8'h60;
    localparam logic [5:0] GPR_PORT_D_DIR     = 6'h11;
    localparam logic [5:0] GPR_PORT_D_OUT     = 6'h12;
    localparam logic [5:0] GPR_PORT_C_PIN     = 6'h13;
    localparam logic [5:0] GPR_PORT_C_DIR     = 6'h14;
    localparam logic [5:0] GPR_PORT_C_OUT     = 6'h15;
    localparam logic [5:0] GPR_PORT_B_PIN     = 6'h16;
    localparam logic [5:0] GPR_PORT_B_DIR     = 6'h17;
    localparam logic [5:0] GPR_PORT_B_OUT     = 6'h18;
    localparam logic [5:0] GPR_PORT_A_PIN     = 6'h19;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] GPR_RESET_BYTE     = 8'h00;
    localparam int         GPR_PORT_C_ZERO_BIT = 7;

    typedef struct packed {
        logic [7:0] out_data;
        logic [7:0] dir;
    } gpr_port_cfg_t;

    typedef struct packed {
        logic [7:0] pin_o;
        logic [7:0] pin_oe_n;
        logic [7:0] pullup_en;
    } gpr_pad_t;
endpackage : gpr_pkg

// File: hw/gpr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gpr_sync (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [7:0] d,
    output var  logic [7:0] q
);
    logic [7:0] meta;
    logic [7:0] next_meta;
    logic [7:0] next_q;

    always_comb begin
        next_meta = ce ? d : meta;
        next_q    = ce ? meta : q;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta <= 8'h00;
            q    <= 8'h00;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule : gpr_sync
`default_nettype wire

// File: hw/gpr_pad.sv
`timescale 1ns/1ps
`default_nettype none
module gpr_pad (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire gpr_pkg::gpr_port_cfg_t cfg,
    input  wire logic                   pullup_disable,
    output var  gpr_pkg::gpr_pad_t      pad
);
    gpr_pkg::gpr_pad_t next_pad;

    always_comb begin
        next_pad.pin_o     = cfg.out_data;
        next_pad.pin_oe_n  = ~cfg.dir;
        next_pad.pullup_en = pullup_disable ? 8'h00 : (~cfg.dir & cfg.out_data);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pad <= '{pin_o: 8'h00, pin_oe_n: 8'hFF, pullup_en: 8'h00};
        end else if (ce) begin
            pad <= next_pad;
        end
    end

    a_pad_drive: assert property (@(posedge mclk) disable iff (rst)
        ce |=> pad.pin_oe_n == ~$past(cfg.dir)) else $error("pad enable wrong");
    a_pullup_off: assert property (@(posedge mclk) disable iff (rst)
        (ce && pullup_disable) |=> pad.pullup_en == 8'h00) else $error("pullup not off");
endmodule : gpr_pad
`default_nettype wire

// File: hw/gpr_bank.sv
`timescale 1ns/1ps
`default_nettype none
module gpr_bank (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       legacy_mode,
    input  wire logic       pullup_disable,
    input  wire logic       io_sel,
    input  wire logic [7:0] addr,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] wdata,
    output var  logic [7:0] rdata,
    input  wire logic [7:0] port_a_pin,
    input  wire logic [7:0] port_b_pin,
    input  wire logic [7:0] port_c_pin,
    output var  logic [7:0] port_b_o,
    output var  logic [7:0] port_b_oe_n,
    output var  logic [7:0] port_b_pullup,
    output logic      [7:0] port_c_o,
    output logic      [7:0] port_c_oe_n,
    output var  logic [7:0] port_c_pullup,
    output var  logic [7:0] port_d_o,
    output var  logic [7:0] port_d_oe_n,
    output var  logic [7:0] port_d_pullup
);
    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Maps either view onto a 6-bit I/O offset; hit is low outside the window.
    function automatic logic [6:0] gpr_decode(input logic io, input logic [7:0] a);
        logic [7:0] off;
        off = a - gpr_pkg::GPR_DATA_IO_BASE;
        if (io)
            return {a[7:6] == 2'b00, a[5:0]};
        // Extended region and below the I/O window are not this bank
        if (a >= gpr_pkg::GPR_DATA_IO_BASE && a < gpr_pkg::GPR_DATA_EXT_BASE)
            return {1'b1, off[5:0]};
        return 7'h00;
    endfunction : gpr_decode

    logic [6:0] dec;
    logic       hit;
    logic [5:0] off;
    assign dec = gpr_decode(io_sel, addr);
    assign hit = dec[6];
    assign off = dec[5:0];

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] sync_c;
    gpr_sync u_sync_a (.mclk(mclk), .rst(rst), .ce(ce), .d(port_a_pin), .q(sync_a));
    gpr_sync u_sync_b (.mclk(mclk), .rst(rst), .ce(ce), .d(port_b_pin), .q(sync_b));
    gpr_sync u_sync_c (.mclk(mclk), .rst(rst), .ce(ce), .d(port_c_pin), .q(sync_c));

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    gpr_pkg::gpr_port_cfg_t port_b;
    gpr_pkg::gpr_port_cfg_t port_c;
    gpr_pkg::gpr_port_cfg_t port_d;
    gpr_pkg::gpr_port_cfg_t next_port_b;
    gpr_pkg::gpr_port_cfg_t next_port_c;
    gpr_pkg::gpr_port_cfg_t next_port_d;
    logic [7:0]             next_rdata;

    always_comb begin
        next_port_b = port_b;
        next_port_c = port_c;
        next_port_d = port_d;
        if (wr && hit) begin
            case (off)
                gpr_pkg::GPR_PORT_B_OUT: next_port_b.out_data = wdata;
                gpr_pkg::GPR_PORT_B_DIR: next_port_b.dir      = wdata;
                gpr_pkg::GPR_PORT_C_OUT: next_port_c.out_data = wdata;
                gpr_pkg::GPR_PORT_C_DIR: next_port_c.dir      = wdata;
                gpr_pkg::GPR_PORT_D_OUT: next_port_d.out_data = wdata;
                gpr_pkg::GPR_PORT_D_DIR: next_port_d.dir      = wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        next_rdata = rdata;
        if (rd) begin
            next_rdata = 8'h00;
            if (hit) begin
                case (off)
                    gpr_pkg::GPR_PORT_A_PIN: next_rdata = sync_a;
                    gpr_pkg::GPR_PORT_B_OUT: next_rdata = port_b.out_data;
                    gpr_pkg::GPR_PORT_B_DIR: next_rdata = port_b.dir;
                    gpr_pkg::GPR_PORT_B_PIN: next_rdata = sync_b;
                    gpr_pkg::GPR_PORT_C_OUT: next_rdata = port_c.out_data;
                    gpr_pkg::GPR_PORT_C_DIR: next_rdata = port_c.dir;
                    gpr_pkg::GPR_PORT_C_PIN: next_rdata = sync_c;
                    gpr_pkg::GPR_PORT_D_OUT: next_rdata = port_d.out_data;
                    gpr_pkg::GPR_PORT_D_DIR: next_rdata = port_d.dir;
                    default:                 next_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            port_b <= '{out_data: gpr_pkg::GPR_RESET_BYTE, dir: gpr_pkg::GPR_RESET_BYTE};
            port_c <= '{out_data: gpr_pkg::GPR_RESET_BYTE, dir: gpr_pkg::GPR_RESET_BYTE};
            port_d <= '{out_data: gpr_pkg::GPR_RESET_BYTE, dir: gpr_pkg::GPR_RESET_BYTE};
            rdata  <= 8'h00;
        end else if (ce) begin
            port_b <= next_port_b;
            port_c <= next_port_c;
            port_d <= next_port_d;
            rdata  <= next_rdata;
        end
    end

    // ----------------------------------------
    // Pad control
    // ----------------------------------------
    gpr_pkg::gpr_pad_t pad_b;
    gpr_pkg::gpr_pad_t pad_c;
    gpr_pkg::gpr_pad_t pad_d;
    gpr_pad u_pad_b (.mclk(mclk), .rst(rst), .ce(ce), .cfg(port_b), .pullup_disable(pullup_disable), .pad(pad_b));
    gpr_pad u_pad_c (.mclk(mclk), .rst(rst), .ce(ce), .cfg(port_c), .pullup_disable(pullup_disable), .pad(pad_c));
    gpr_pad u_pad_d (.mclk(mclk), .rst(rst), .ce(ce), .cfg(port_d), .pullup_disable(pullup_disable), .pad(pad_d));

    // Legacy override is a pure gate on a static strap, so it holds with mclk stopped
    // and even while rst is asserted; port_c_o, port_c_oe_n and port_c_pullup are the only outputs not taken from a flop.
    assign port_c_o    = legacy_mode ? 8'h00 : pad_c.pin_o;
    assign port_c_oe_n = legacy_mode ? 8'h00 : pad_c.pin_oe_n;

    always_comb begin
        port_b_o      = pad_b.pin_o;
        port_b_oe_n   = pad_b.pin_oe_n;
        port_b_pullup = pad_b.pullup_en;
        port_c_pullup = legacy_mode ? 8'h00 : pad_c.pullup_en;
        port_d_o      = pad_d.pin_o;
        port_d_oe_n   = pad_d.pin_oe_n;
        port_d_pullup = pad_d.pullup_en;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_io_write(logic [5:0] o);
        ce && wr && io_sel && addr == {2'b00, o};
    endsequence

    a_b_out_write: assert property (@(posedge mclk) disable iff (rst)
        s_io_write(gpr_pkg::GPR_PORT_B_OUT) |=> port_b.out_data == $past(wdata)) else $error("port b data");
    a_c_dir_write: assert property (@(posedge mclk) disable iff (rst)
        s_io_write(gpr_pkg::GPR_PORT_C_DIR) |=> port_c.dir == $past(wdata)) else $error("port c dir");
    a_d_dir_write: assert property (@(posedge mclk) disable iff (rst)
        s_io_write(gpr_pkg::GPR_PORT_D_DIR) |=> port_d.dir == $past(wdata)) else $error("port d dir");
    a_data_view: assert property (@(posedge mclk) disable iff (rst)
        (ce && wr && !io_sel && addr == 8'h32) |=> port_d.out_data == $past(wdata)) else $error("data view");
    a_ext_ignored: assert property (@(posedge mclk) disable iff (rst)
        (ce && wr && !io_sel && addr >= 8'h60) |=> $stable(port_b)) else $error("ext hit");
    a_io_range: assert property (@(posedge mclk) disable iff (rst)
        (ce && wr && io_sel && addr > 8'h3F) |=> $stable(port_c)) else $error("io range");
    a_pin_a_read: assert property (@(posedge mclk) disable iff (rst)
        (ce && rd && io_sel && addr == 8'h19) |=> rdata == $past(sync_a)) else $error("pin a read");
    a_legacy_low: assert property (@(posedge mclk)
        legacy_mode |-> port_c_oe_n == 8'h00 && port_c_o == 8'h00) else $error("legacy port c");
endmodule : gpr_bank
`default_nettype wire

// File: dv/gpr_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpr_ext_model (
    input  wire logic              ext_en,
    input  wire logic [7:0]        ext_a,
    input  wire logic [7:0]        ext_b,
    input  wire logic [7:0]        ext_c,
    input  wire gpr_pkg::gpr_pad_t pad_b,
    input  wire gpr_pkg::gpr_pad_t pad_c,
    output wire logic [7:0]        pin_a,
    output wire logic [7:0]        pin_b,
    output wire logic [7:0]        pin_c
);
    // With ext_en low, released lines read 1 where pulled up, else the inverse of the far-side value, so stale values never pass
    function automatic logic [7:0] level(input gpr_pkg::gpr_pad_t p, input logic [7:0] e, input logic en);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            if (!p.pin_oe_n[i])
                r[i] = p.pin_o[i];
            else if (en)
                r[i] = e[i];
            else
                r[i] = p.pullup_en[i] ? 1'b1 : ~e[i];
        end
        return r;
    endfunction : level

    assign pin_a = ext_en ? ext_a : ~ext_a;
    assign pin_b = level(pad_b, ext_b, ext_en);
    assign pin_c = level(pad_c, ext_c, ext_en);
endmodule : gpr_ext_model
`default_nettype wire

// File: dv/test_gpr_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_gpr_bank;
    typedef struct {logic io; logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] exp;} gpr_row_t;
    logic       mclk, rst, ce, legacy_mode, pullup_disable, io_sel, wr, rd, ext_en;
    logic [7:0] addr, wdata, rdata, ext_a, ext_b, ext_c, pa, pb, pc;
    logic [7:0] b_o, b_oe_n, b_pu, c_o, c_oe_n, c_pu, d_o, d_oe_n, d_pu;
    int         num_errors = 0;
    int         tests_run = 0;
    gpr_row_t   rows[10] = '{
        '{1'b1, 8'h11, 8'h3C, 8'h11, 8'h3C}, '{1'b1, 8'h12, 8'hC3, 8'h12, 8'hC3},
        '{1'b1, 8'h14, 8'h5A, 8'h14, 8'h5A}, '{1'b1, 8'h15, 8'hA5, 8'h15, 8'hA5},
        '{1'b0, 8'h37, 8'h0F, 8'h17, 8'h0F}, '{1'b0, 8'h38, 8'hF0, 8'h18, 8'hF0},
        '{1'b0, 8'h17, 8'hFF, 8'h17, 8'h0F}, '{1'b0, 8'h77, 8'hFF, 8'h18, 8'hF0},
        '{1'b1, 8'h57, 8'hFF, 8'h17, 8'h0F}, '{1'b1, 8'h40, 8'h00, 8'h40, 8'h00}};

    gpr_bank dut (.mclk(mclk), .rst(rst), .ce(ce), .legacy_mode(legacy_mode), .pullup_disable(pullup_disable),
        .io_sel(io_sel), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata),
        .port_a_pin(pa), .port_b_pin(pb), .port_c_pin(pc), .port_b_o(b_o), .port_b_oe_n(b_oe_n),
        .port_b_pullup(b_pu), .port_c_o(c_o), .port_c_oe_n(c_oe_n), .port_c_pullup(c_pu),
        .port_d_o(d_o), .port_d_oe_n(d_oe_n), .port_d_pullup(d_pu));
    gpr_ext_model partner (.ext_en(ext_en), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c),
        .pad_b({b_o, b_oe_n, b_pu}), .pad_c({c_o, c_oe_n, c_pu}), .pin_a(pa), .pin_b(pb), .pin_c(pc));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_wr(input logic io, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_sel = io;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
    endtask : bus_wr

    // I/O view read, rdata checked at the next falling edge, half a cycle after the strobe is taken
    task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        io_sel = 1'b1;
        addr = a;
        rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
        check(rdata, exp);
    endtask : bus_rd

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    initial begin
        #(8 * 3000);
        num_errors++;
        wrap_up();
    end

    initial begin
        {rst, ce, legacy_mode, pullup_disable, io_sel, wr, rd} = 7'b1100000;
        {addr, wdata, ext_a, ext_b, ext_c, ext_en} = {8'h00, 8'h00, 8'h96, 8'h3C, 8'h81, 1'b1};
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        check(b_oe_n, 8'hFF);
        foreach (rows[i]) bus_rd(rows[i].wa & 8'h1F, 8'h00);
        $display("test reset values done");
        bus_wr(1'b1, 8'h16, 8'hFF);
        bus_rd(8'h19, 8'h96);
        bus_rd(8'h16, 8'h3C);
        bus_rd(8'h13, 8'h81);
        $display("test pin inputs done");
        foreach (rows[i]) begin
            bus_wr(rows[i].io, rows[i].wa, rows[i].wd);
            bus_rd(rows[i].ra, rows[i].exp);
        end
        $display("test register map done");
        repeat (2) @(negedge mclk);
        check(b_oe_n, 8'hF0);
        check(b_o, 8'hF0);
        check(d_oe_n, 8'hC3);
        check(d_o, 8'hC3);
        check(d_pu, 8'hC3);
        check(c_o, 8'hA5);
        check(c_oe_n, 8'hA5);
        check(c_pu, 8'hA5);
        bus_rd(8'h16, 8'h30);
        check(b_pu, 8'hF0);
        pullup_disable = 1'b1;
        repeat (3) @(negedge mclk);
        check(b_pu, 8'h00);
        // Released far side: undriven inputs show the inverse level
        ext_en = 1'b0;
        repeat (3) @(negedge mclk);
        bus_rd(8'h16, 8'hC0);
        bus_rd(8'h19, 8'h69);
        ext_en = 1'b1;
        repeat (3) @(negedge mclk);
        $display("test drive and pull-ups done");
        ce = 1'b0;
        legacy_mode = 1'b1;
        #1;
        check(c_oe_n | c_o, 8'h00);
        check(c_pu, 8'h00);
        ce = 1'b1;
        bus_rd(8'h15, 8'hA5);
        rst = 1'b1;
        #1;
        check(c_oe_n, 8'h00);
        $display("test legacy mode done");
        wrap_up();
    end
endmodule : test_gpr_bank
`default_nettype wire
